// ==== dtd_decoder.sv ====
// decoder for data transfer opcodes and the register/memory form of add with carry
`timescale 1ns/1ps
`default_nettype none

// What this block does
// RQ1 - 8E with mode bit5 zero: load segment
// RQ2 - 8C with mode bit5 zero: store segment
// RQ3 - D7 alone: table translate into low accumulator
// RQ4 - 8D plus modrm: load effective address
// RQ5 - C5 plus modrm: far pointer, data segment
// RQ6 - C4 plus modrm: far pointer, extra segment
// RQ7 - 9F alone: flags into high accumulator
// RQ8 - 9E alone: high accumulator into flags
// RQ9 - 000100dw plus modrm: add with carry
// RQ10 - w zero byte, one word operand
// RQ11 - d one makes reg field destination
module dtd_decoder
	import dtd_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [7:0] byte_in,
	input wire logic byte_valid,
	output logic byte_ready,
	output var dtd_decode_t decode,
	output logic decode_valid
);
	// ----------------------------------------
	// classification helpers
	// ----------------------------------------
	function automatic logic needs_modrm(input logic [7:0] opc);
		needs_modrm = (opc == OPC_SEG_LOAD) || (opc == OPC_SEG_STORE)
			|| (opc == OPC_EFF_ADDR) || (opc == OPC_FAR_DATA)
			|| (opc == OPC_FAR_EXTRA) || (opc[7:2] == OPC_ADC_HIGH);
	endfunction

	function automatic dtd_op_t single_op(input logic [7:0] opc);
		unique case (opc)
			OPC_TABLE_TRANSLATE_OP_BYTE: single_op = DTD_OP_TABLE_TRANSLATE; // [RQ3]
			OPC_FLAGS_TO_AH: single_op = DTD_OP_FLAGS_TO_ACC_HIGH; // [RQ7]
			OPC_AH_TO_FLAGS: single_op = DTD_OP_ACC_HIGH_TO_FLAGS; // [RQ8]
			default: single_op = DTD_OP_NONE;
		endcase
	endfunction

	// ----------------------------------------
	// state
	// ----------------------------------------
	dtd_state_t state, next_state;
	logic [7:0] held_opcode, next_held_opcode;
	dtd_decode_t next_decode;
	logic next_decode_valid;

	// always ready: one byte per clock, no stall is ever needed
	assign byte_ready = 1'b1;

	always_comb begin
		next_state = state;
		next_held_opcode = held_opcode;
		next_decode = decode;
		next_decode_valid = 1'b0;
		if (byte_valid) begin
			unique case (state)
				DTD_ST_OPCODE: begin
					if (needs_modrm(byte_in)) begin
						next_held_opcode = byte_in;
						next_state = DTD_ST_MODRM;
					end else begin
						next_decode = '0;
						next_decode.opcode = byte_in;
						next_decode.op = single_op(byte_in);
						// single-byte ops here all work on bytes
						next_decode_valid = 1'b1;
					end
				end
				DTD_ST_MODRM: begin
					next_state = DTD_ST_OPCODE;
					next_decode_valid = 1'b1;
					next_decode.opcode = held_opcode;
					next_decode.mode = byte_in[7:6];
					next_decode.reg_field = byte_in[5:3];
					next_decode.rm_field = byte_in[2:0];
					next_decode.word_op = 1'b1;
					next_decode.reg_is_dest = 1'b1;
					unique case (held_opcode)
						OPC_SEG_LOAD: begin
							// only four segment registers: bit5 set is illegal
							next_decode.op = byte_in[SEG_ZERO_BIT] ? DTD_OP_ILLEGAL
								: DTD_OP_MOVE_TO_SEG; // [RQ1]
						end
						OPC_SEG_STORE: begin
							next_decode.op = byte_in[SEG_ZERO_BIT] ? DTD_OP_ILLEGAL
								: DTD_OP_MOVE_FROM_SEG; // [RQ2]
							next_decode.reg_is_dest = 1'b0;
						end
						OPC_EFF_ADDR: next_decode.op = DTD_OP_LOAD_EFF_ADDR; // [RQ4]
						OPC_FAR_DATA: next_decode.op = DTD_OP_LOAD_FAR_DATA_SEG; // [RQ5]
						OPC_FAR_EXTRA: next_decode.op = DTD_OP_LOAD_FAR_EXTRA_SEG; // [RQ6]
						default: begin
							next_decode.op = DTD_OP_ADD_CARRY; // [RQ9]
							next_decode.word_op = held_opcode[W_BIT]; // [RQ10]
							next_decode.reg_is_dest = held_opcode[D_BIT]; // [RQ11]
						end
					endcase
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state <= DTD_ST_OPCODE;
			held_opcode <= 8'h00;
			decode <= '0;
			decode_valid <= 1'b0;
		end else begin
			state <= next_state;
			held_opcode <= next_held_opcode;
			decode <= next_decode;
			decode_valid <= next_decode_valid;
		end
	end
endmodule
`default_nettype wire

// ==== dtd_decoder_tb_top.sv ====
// self-checking bench for the opcode decoder
`timescale 1ns/1ps
`default_nettype none
module dtd_decoder_tb_top;
	import dtd_pkg::*;
	logic clk = 1'b0, rst_n = 1'b0;
	wire logic [7:0] byte_in;
	wire logic byte_valid, decode_valid, byte_ready;
	dtd_decode_t decode;
	int n_mismatch = 0, checks_done = 0;
	dtd_queue q (.clk(clk), .byte_in(byte_in), .byte_valid(byte_valid));
	dtd_decoder DUT (.clk(clk), .rst_n(rst_n), .byte_in(byte_in), .byte_valid(byte_valid),
		.byte_ready(byte_ready), .decode(decode), .decode_valid(decode_valid));
	initial forever #10 clk = ~clk;
	task automatic chk(input logic [31:0] seen, exp);
		checks_done++;
		n_mismatch += int'(seen !== exp);
		if (seen !== exp) $display("wrong value at %0t: %h not %h", $time, seen, exp);
	endtask
	task automatic results;
		$display("mismatches %0d checks %0d", n_mismatch, checks_done);
		if (n_mismatch == 0 && checks_done > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	// ex is {op, word_op, reg_is_dest}; gap below zero means a one-byte opcode
	task automatic ins(input logic [7:0] b0, b1, input int gap, input logic [5:0] ex);
		q.put(b0, 1'b1);
		if (gap >= 0) begin
			repeat (gap) q.put(b0, 1'b0);
			q.put(b1, 1'b1);
		end
		q.put(b0, 1'b0);
		chk({decode_valid, decode}, {1'b1, ex, b1, b0});
		q.put(b0, 1'b0);
		chk(decode_valid, 1'b0);
	endtask
	task automatic t_seg;
		ins(OPC_SEG_LOAD, 8'hD8, 0, 6'h07);
		ins(OPC_SEG_LOAD, 8'h20, 2, 6'h3F);
		ins(OPC_SEG_STORE, 8'h46, 1, 6'h0A);
		ins(OPC_SEG_STORE, 8'h66, 0, 6'h3E);
	endtask
	// reset while an opcode waits for its mode byte must drop the pending opcode
	task automatic t_reset;
		q.put(OPC_EFF_ADDR, 1'b1);
		q.put(8'h00, 1'b0);
		rst_n = 1'b0;
		q.put(8'h00, 1'b0);
		chk({byte_ready, decode_valid, decode}, {1'b1, 23'h000000});
		rst_n = 1'b1;
		ins(OPC_TABLE_TRANSLATE_OP_BYTE, 8'h00, -1, 6'h0C);
		ins(8'h90, 8'h00, -1, 6'h00);
	endtask
	task automatic t_other;
		ins(OPC_TABLE_TRANSLATE_OP_BYTE, 8'h00, -1, 6'h0C);
		ins(OPC_EFF_ADDR, 8'h46, 0, 6'h13);
		ins(OPC_FAR_DATA, 8'h9F, 3, 6'h17);
		ins(OPC_FAR_EXTRA, 8'hC1, 0, 6'h1B);
		ins(OPC_FLAGS_TO_AH, 8'h00, -1, 6'h1C);
		ins(OPC_AH_TO_FLAGS, 8'h00, -1, 6'h20);
		for (int i = 0; i < 4; i++)
			ins({OPC_ADC_HIGH, i[1:0]}, 8'h2B, i, {4'h9, i[0], i[1]});
	endtask
	initial begin
		repeat (2) @(negedge clk);
		rst_n = 1'b1;
		t_seg();
		t_other();
		t_reset();
		results();
	end
	initial begin
		repeat (400) @(posedge clk);
		n_mismatch++;
		results();
	end
endmodule
`default_nettype wire

// ==== dtd_pkg.sv ====
// shared constants and types for the data transfer opcode decoder
package dtd_pkg;
	// ----------------------------------------
	// opcode bytes, and the high six bits of add with carry
	// ----------------------------------------
	localparam logic [7:0] OPC_SEG_LOAD = 8'h8E;
	localparam logic [7:0] OPC_SEG_STORE = 8'h8C;
	localparam logic [7:0] OPC_TABLE_TRANSLATE_OP_BYTE = 8'hD7;
	localparam logic [7:0] OPC_EFF_ADDR = 8'h8D;
	localparam logic [7:0] OPC_FAR_DATA = 8'hC5;
	localparam logic [7:0] OPC_FAR_EXTRA = 8'hC4;
	localparam logic [7:0] OPC_FLAGS_TO_AH = 8'h9F;
	localparam logic [7:0] OPC_AH_TO_FLAGS = 8'h9E;
	localparam logic [5:0] OPC_ADC_HIGH = 6'h04;
	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int W_BIT = 0;
	localparam int D_BIT = 1;
	localparam int SEG_ZERO_BIT = 5;

	typedef enum logic [3:0] {
		DTD_OP_NONE = 4'h0,
		DTD_OP_MOVE_TO_SEG = 4'h1,
		DTD_OP_MOVE_FROM_SEG = 4'h2,
		DTD_OP_TABLE_TRANSLATE = 4'h3,
		DTD_OP_LOAD_EFF_ADDR = 4'h4,
		DTD_OP_LOAD_FAR_DATA_SEG = 4'h5,
		DTD_OP_LOAD_FAR_EXTRA_SEG = 4'h6,
		DTD_OP_FLAGS_TO_ACC_HIGH = 4'h7,
		DTD_OP_ACC_HIGH_TO_FLAGS = 4'h8,
		DTD_OP_ADD_CARRY = 4'h9,
		DTD_OP_ILLEGAL = 4'hF
	} dtd_op_t;

	typedef enum logic [0:0] {
		DTD_ST_OPCODE = 1'b0,
		DTD_ST_MODRM = 1'b1
	} dtd_state_t;

	typedef struct packed {
		dtd_op_t op;
		logic word_op;
		logic reg_is_dest;
		logic [1:0] mode;
		logic [2:0] reg_field;
		logic [2:0] rm_field;
		logic [7:0] opcode;
	} dtd_decode_t;
endpackage

// ==== dtd_props.sv ====
// port assertions for the opcode decoder
`timescale 1ns/1ps
`default_nettype none
module dtd_props
	import dtd_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [7:0] byte_in,
	input wire dtd_decode_t decode,
	input wire logic decode_valid
);
	wire logic v = decode_valid;
	wire logic [7:0] oc = decode.opcode;
	wire logic [3:0] op = decode.op;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	property p_sl; v && oc == 8'h8E |-> op == (decode.reg_field[2] ? 4'hF : 4'h1); endproperty
	a_sl: assert property (p_sl) else $error("bad op");
	property p_ss; v && oc == 8'h8C |-> op == (decode.reg_field[2] ? 4'hF : 4'h2); endproperty
	a_ss: assert property (p_ss) else $error("bad op");
	property p_tt; v && op == 4'h3 |-> $past(byte_in) == 8'hD7; endproperty
	a_tt: assert property (p_tt) else $error("bad op");
	property p_ea; v && oc == 8'h8D |-> op == 4'h4 && decode.reg_is_dest; endproperty
	a_ea: assert property (p_ea) else $error("bad op");
	property p_fd; v && oc == 8'hC5 |-> op == 4'h5; endproperty
	a_fd: assert property (p_fd) else $error("bad op");
	property p_fe; v && oc == 8'hC4 |-> op == 4'h6; endproperty
	a_fe: assert property (p_fe) else $error("bad op");
	property p_fl; v && oc[7:1] == 7'h4F |-> op == (oc[0] ? 4'h7 : 4'h8); endproperty
	a_fl: assert property (p_fl) else $error("bad op");
	property p_ac; v && oc[7:2] == 6'h04 |-> op == 4'h9 && decode[17:16] == {oc[0], oc[1]}
		&& decode[15:8] == $past(byte_in); endproperty
	a_ac: assert property (p_ac) else $error("bad op");
endmodule
bind dtd_decoder dtd_props u_props (.clk(clk), .rst_n(rst_n), .byte_in(byte_in),
	.decode(decode), .decode_valid(decode_valid));
`default_nettype wire

// ==== dtd_queue.sv ====
// prefetch queue model
`timescale 1ns/1ps
`default_nettype none
module dtd_queue (
	input wire logic clk,
	output logic [7:0] byte_in = 8'h00,
	output logic byte_valid = 1'b0
);
	task automatic put(input logic [7:0] b, input logic en);
		@(negedge clk);
		byte_valid = en;
		// empty slot shows the inverse so a stale byte never looks new
		byte_in = en ? b : ~byte_in;
	endtask
endmodule
`default_nettype wire
